// >>> design/anc_sys_consts.vh
`ifndef ANC_SYS_CONSTS_VH
`define ANC_SYS_CONSTS_VH

// register offsets
`define ANC_CHIP_CONTROL_ADDR 8'h20
`define ANC_POWER_STATUS_ADDR 8'h21
`define ANC_EVAL_FIRST_ADDR 8'h3d
`define ANC_EVAL_LAST_ADDR 8'h3f

// chip_control fields
`define ANC_REVISION_MSB 7
`define ANC_REVISION_LSB 4
`define ANC_UNLOCK_BIT 3
`define ANC_KEEP_ALIVE_BIT 0
`define ANC_UNLOCK_RESET 1'b0
`define ANC_KEEP_ALIVE_RESET 1'b1

// power_status fields
`define ANC_BROWNOUT_BIT 6
`define ANC_STARTUP_DONE_BIT 5
`define ANC_HEADPHONE_BIT 4
`define ANC_MIC_PREAMP_BIT 3
`define ANC_LINE_IN_BIT 2
`define ANC_MIC_PUMP_BIT 1
`define ANC_MIC_SUPPLY_BIT 0
`define ANC_POWER_STATUS_RESET 8'h20

// two-wire bus framing and eval register reset value
`define ANC_BITS_PER_BYTE 4'h8
`define ANC_LAST_TX_BIT 4'h7
`define ANC_DEVICE_ADDR 7'h40
`define ANC_EVAL_RESET 8'h00

`endif

// >>> design/anc_bus_cond.v
`default_nettype none

// brings the two-wire bus pins into the ref_clk domain and finds edges
module anc_bus_cond (
  input wire ref_clk,
  input wire rst,
  input wire sclPin,
  input wire sdaPin,
  output reg sdaLevel,
  output wire sclRise,
  output wire sclFall,
  output wire startSeen,
  output wire stopSeen
);

  reg sclMeta;
  reg sdaMeta;
  reg sclLevel;
  reg sclLast;
  reg sdaLast;

  // first stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (rst) begin
      sclMeta <= 1'b1;
      sdaMeta <= 1'b1;
      sclLevel <= 1'b1;
      sdaLevel <= 1'b1;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclMeta <= sclPin;
      sdaMeta <= sdaPin;
      sclLevel <= sclMeta;
      sdaLevel <= sdaMeta;
      sclLast <= sclLevel;
      sdaLast <= sdaLevel;
    end
  end

  assign sclRise = sclLevel & ~sclLast;
  assign sclFall = ~sclLevel & sclLast;
  // data moving while clock is high frames a transfer
  assign startSeen = sclLevel & sclLast & sdaLast & ~sdaLevel;
  assign stopSeen = sclLevel & sclLast & ~sdaLast & sdaLevel;

endmodule // anc_bus_cond

`default_nettype wire

// >>> design/anc_system_power_registers.v
`include "anc_sys_consts.vh"
`default_nettype none

module anc_system_power_registers (
  input wire ref_clk,
  input wire rst,
  input wire sclPin,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe_n,
  input wire i2cCtrlSelect,
  input wire batteryBrownout,
  input wire startupDone,
  input wire headphoneAmpOn,
  input wire micPreampOn,
  input wire lineInOn,
  input wire micPumpOn,
  input wire micSupplyOn,
  output reg powerKeepAlive,
  output wire chipPowerDown,
  output reg evaluationWriteUnlock,
  output reg [23:0] evalConfig
);

  // arbitrary neutral revision code
  parameter [3:0] SILICON_REVISION = 4'h3;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_PTR = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_ACK = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  wire sdaLevel;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;

  reg [2:0] state;
  reg [2:0] afterAck;
  reg [3:0] bitCnt;
  reg [7:0] rxShift;
  reg [7:0] txShift;
  reg [7:0] regPtr;
  reg masterAcked;
  reg [6:0] statusMeta;
  reg [6:0] statusSync;

  anc_bus_cond u_cond (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclPin(sclPin),
    .sdaPin(sdaIn),
    .sdaLevel(sdaLevel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // open drain: only ever pulls low
  assign sdaOut = 1'b0;

  // power-down only takes effect with the two-wire select bit set
  assign chipPowerDown = ~powerKeepAlive & i2cCtrlSelect;

  function isEval;
    input [7:0] addr;
    begin
      isEval = (addr >= `ANC_EVAL_FIRST_ADDR) &&
               (addr <= `ANC_EVAL_LAST_ADDR);
    end
  endfunction

  function [1:0] evalIndex;
    input [7:0] addr;
    reg [7:0] diff;
    begin
      diff = addr - `ANC_EVAL_FIRST_ADDR;
      evalIndex = diff[1:0];
    end
  endfunction

  // monitored blocks live outside this clock domain
  always @(posedge ref_clk) begin
    if (rst) begin
      statusMeta <= 7'h00;
      statusSync <= 7'h00;
    end else begin
      statusMeta <= {batteryBrownout, startupDone, headphoneAmpOn,
                     micPreampOn, lineInOn, micPumpOn, micSupplyOn};
      statusSync <= statusMeta;
    end
  end

  wire [7:0] powerStatus;
  assign powerStatus[7] = 1'b0;
  assign powerStatus[`ANC_BROWNOUT_BIT] = statusSync[6];
  assign powerStatus[`ANC_STARTUP_DONE_BIT] = statusSync[5];
  assign powerStatus[`ANC_HEADPHONE_BIT] = statusSync[4];
  assign powerStatus[`ANC_MIC_PREAMP_BIT] = statusSync[3];
  assign powerStatus[`ANC_LINE_IN_BIT] = statusSync[2];
  assign powerStatus[`ANC_MIC_PUMP_BIT] = statusSync[1];
  assign powerStatus[`ANC_MIC_SUPPLY_BIT] = statusSync[0];

  wire [7:0] chipControl;
  assign chipControl[`ANC_REVISION_MSB:`ANC_REVISION_LSB] =
    SILICON_REVISION;
  assign chipControl[`ANC_UNLOCK_BIT] = evaluationWriteUnlock;
  assign chipControl[2:1] = 2'h0;
  assign chipControl[`ANC_KEEP_ALIVE_BIT] = powerKeepAlive;

  reg [7:0] readData;
  always @* begin
    readData = 8'h00;
    if (regPtr == `ANC_CHIP_CONTROL_ADDR) begin
      readData = chipControl;
    end else if (regPtr == `ANC_POWER_STATUS_ADDR) begin
      readData = powerStatus;
    end else if (isEval(regPtr)) begin
      case (evalIndex(regPtr))
        2'h0: readData = evalConfig[7:0];
        2'h1: readData = evalConfig[15:8];
        2'h2: readData = evalConfig[23:16];
        default: readData = 8'h00;
      endcase
    end
  end

  wire byteDone = (bitCnt == `ANC_BITS_PER_BYTE);
  wire writeNow = sclFall && byteDone && (state == ST_WDATA);

  // register writes land on the falling clock edge closing a data byte
  always @(posedge ref_clk) begin
    if (rst) begin
      evaluationWriteUnlock <= `ANC_UNLOCK_RESET;
      powerKeepAlive <= `ANC_KEEP_ALIVE_RESET;
      evalConfig <= {3{`ANC_EVAL_RESET}};
    end else begin
      if (writeNow && regPtr == `ANC_CHIP_CONTROL_ADDR) begin
        // revision bits have no storage, so writes fall away
        evaluationWriteUnlock <= rxShift[`ANC_UNLOCK_BIT];
        powerKeepAlive <= rxShift[`ANC_KEEP_ALIVE_BIT];
      end
      if (writeNow && isEval(regPtr) && evaluationWriteUnlock) begin
        case (evalIndex(regPtr))
          2'h0: evalConfig[7:0] <= rxShift;
          2'h1: evalConfig[15:8] <= rxShift;
          default: evalConfig[23:16] <= rxShift;
        endcase
      end
      // wake wins over a clearing write in the same cycle
      if (startSeen) begin
        powerKeepAlive <= 1'b1;
      end
    end
  end

  // byte engine of the two-wire slave
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      afterAck <= ST_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      regPtr <= 8'h00;
      masterAcked <= 1'b0;
      sdaOe_n <= 1'b1;
    end else if (startSeen) begin
      state <= ST_ADDR;
      bitCnt <= 4'h0;
      sdaOe_n <= 1'b1;
    end else if (stopSeen) begin
      state <= ST_IDLE;
      sdaOe_n <= 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise && !byteDone) begin
            rxShift <= {rxShift[6:0], sdaLevel};
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall && byteDone) begin
            bitCnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (rxShift[7:1] == `ANC_DEVICE_ADDR) begin
                afterAck <= rxShift[0] ? ST_RDATA : ST_PTR;
                sdaOe_n <= 1'b0;
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              if (state == ST_PTR) begin
                regPtr <= rxShift;
              end else begin
                regPtr <= regPtr + 8'h01;
              end
              afterAck <= ST_WDATA;
              sdaOe_n <= 1'b0;
              state <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (afterAck == ST_RDATA) begin
              txShift <= readData;
              sdaOe_n <= readData[7];
              regPtr <= regPtr + 8'h01;
            end else begin
              sdaOe_n <= 1'b1;
            end
            state <= afterAck;
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt == `ANC_LAST_TX_BIT) begin
              sdaOe_n <= 1'b1;
              bitCnt <= 4'h0;
              state <= ST_RACK;
            end else begin
              sdaOe_n <= txShift[6];
              txShift <= {txShift[6:0], 1'b0};
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            masterAcked <= ~sdaLevel;
          end else if (sclFall) begin
            if (masterAcked) begin
              txShift <= readData;
              sdaOe_n <= readData[7];
              regPtr <= regPtr + 8'h01;
              state <= ST_RDATA;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          sdaOe_n <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // anc_system_power_registers

`default_nettype wire

// >>> dv/aspr_props.sv
`default_nettype none
module aspr_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclPin,
  input wire logic sdaIn,
  input wire logic sdaOe_n,
  input wire logic i2cCtrlSelect,
  input wire logic powerKeepAlive,
  input wire logic chipPowerDown,
  input wire logic evaluationWriteUnlock,
  input wire logic [23:0] evalConfig
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_start; sclPin && $fell(sdaIn); endsequence
  // register updates land with the acknowledge of their byte
  sequence s_ack; ##[0:4] !sdaOe_n; endsequence
  property p_wake; s_start |-> ##[1:6] powerKeepAlive; endproperty
  property p_pdown;
    chipPowerDown == (!powerKeepAlive && i2cCtrlSelect);
  endproperty
  property p_rst_ka; $fell(rst) |-> powerKeepAlive; endproperty
  property p_rst_unl; $fell(rst) |-> !evaluationWriteUnlock; endproperty
  property p_lock;
    !evaluationWriteUnlock && !$past(evaluationWriteUnlock)
      |-> $stable(evalConfig);
  endproperty
  property p_eval_ack; $changed(evalConfig) |-> s_ack; endproperty
  property p_ka_fall; $fell(powerKeepAlive) |-> s_ack; endproperty
  property p_unl_ack; $changed(evaluationWriteUnlock) |-> s_ack; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  a_pdown: assert property (p_pdown) else $error("bad powerdown");
  a_rst_ka: assert property (p_rst_ka) else $error("bad keepalive");
  a_rst_unl: assert property (p_rst_unl) else $error("bad unlock");
  a_lock: assert property (p_lock) else $error("locked write");
  a_eval_ack: assert property (p_eval_ack) else $error("eval upd");
  a_ka_fall: assert property (p_ka_fall) else $error("ka upd");
  a_unl_ack: assert property (p_unl_ack) else $error("unl upd");
endmodule // aspr_props
bind anc_system_power_registers aspr_props u_props (.ref_clk(ref_clk),
  .rst(rst), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOe_n(sdaOe_n),
  .i2cCtrlSelect(i2cCtrlSelect), .powerKeepAlive(powerKeepAlive),
  .chipPowerDown(chipPowerDown), .evalConfig(evalConfig),
  .evaluationWriteUnlock(evaluationWriteUnlock));
`default_nettype wire

// >>> dv/aspr_i2c_host.sv
`default_nettype none
module aspr_i2c_host (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sdaDrv,
  output logic [7:0] rdByte,
  output logic rdDone,
  output logic ackOk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] devAddr = 7'h40;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    rdDone = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // a==b: data bit; 1,0: start; 0,1: stop (scl left high)
  task automatic pulse(input logic a, input logic b, output logic s);
    sdaDrv = a;
    tick(4);
    scl = 1'b1;
    tick(5);
    s = sda;
    sdaDrv = b;
    tick(5);
    if (a || !b) begin
      scl = 1'b0;
      tick(4);
    end
  endtask
  task automatic xfer(input logic [7:0] tx, input logic a9, output logic ack);
    for (int i = 7; i >= 0; i--) pulse(tx[i], tx[i], rdByte[i]);
    pulse(a9, a9, ack);
    ack = !ack;
  endtask
  task automatic head(input logic [7:0] p);
    logic a;
    pulse(1'b1, 1'b0, a);
    xfer({devAddr, 1'b0}, 1'b1, ackOk);
    xfer(p, 1'b1, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic a;
    head(p);
    foreach (d[i]) xfer(d[i], 1'b1, a);
    pulse(1'b0, 1'b1, a);
  endtask
  // master nacks the last byte so the device lets go of the data line
  task automatic rd(input logic [7:0] p, input int n);
    logic a;
    head(p);
    pulse(1'b1, 1'b0, a);
    xfer({devAddr, 1'b1}, 1'b1, a);
    for (int i = 1; i <= n; i++) begin
      xfer(8'hff, i == n, a);
      rdDone = 1'b1;
      tick(1);
      rdDone = 1'b0;
    end
    pulse(1'b0, 1'b1, a);
  endtask
endmodule // aspr_i2c_host
`default_nettype wire

// >>> dv/test_anc_system_power_registers.sv
`default_nettype none
module test_anc_system_power_registers;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] REV = 4'h5; // arbitrary revision code
  logic ref_clk, rst, sel, scl, hostSda, sdaOut, sdaOe_n, ka, pd, unl;
  logic rdDone, ackOk;
  logic [6:0] stat;
  logic [7:0] rdByte;
  logic [23:0] evalCfg, ev;
  logic [7:0] expQ[$];
  int err_count = 0;
  int tests_run = 0;
  // pulled-up line: low if either side pulls
  wire logic sda = hostSda & (sdaOe_n | sdaOut);
  anc_system_power_registers #(.SILICON_REVISION(REV)) DUT (
    .ref_clk(ref_clk), .rst(rst), .sclPin(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .i2cCtrlSelect(sel),
    .batteryBrownout(stat[6]), .startupDone(stat[5]),
    .headphoneAmpOn(stat[4]), .micPreampOn(stat[3]), .lineInOn(stat[2]),
    .micPumpOn(stat[1]), .micSupplyOn(stat[0]), .powerKeepAlive(ka),
    .chipPowerDown(pd), .evaluationWriteUnlock(unl), .evalConfig(evalCfg));
  aspr_i2c_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sdaDrv(hostSda), .rdByte(rdByte), .rdDone(rdDone), .ackOk(ackOk));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
    foreach (e[i]) expQ.push_back(e[i]);
    host.rd(p, e.size());
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge rdDone) chk(24'(rdByte), 24'(expQ.pop_front()));
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    stat = 7'h00;
    void'($urandom(32'h36f20113));
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    host.tick(4);
    chk(24'(ka), 24'h1);
    rd(8'h20, '{{REV, 4'h1}});
    chk(24'(ackOk), 24'h1);
    $display("reset values done");
    for (int i = 0; i < 5; i++) begin
      stat = i == 0 ? 7'h00 : i == 1 ? 7'h7f : 7'($urandom);
      host.wr(8'h21, '{{1'b1, ~stat}});
      rd(8'h21, '{{1'b0, stat}});
    end
    $display("status done");
    sel = 1'b1; // select raised before keep-alive is cleared
    host.wr(8'h20, '{8'hfe});
    chk(24'(ka), 24'h0);
    chk(24'(pd), 24'h1);
    chk(24'(unl), 24'h1);
    rd(8'h20, '{{REV, 4'h9}});
    chk(24'(pd), 24'h0);
    $display("power down done");
    ev = 24'($urandom);
    host.wr(8'h3d, '{ev[7:0], ev[15:8], ev[23:16]});
    chk(evalCfg, ev);
    rd(8'h3d, '{ev[7:0], ev[15:8], ev[23:16]});
    host.wr(8'h20, '{8'h01});
    host.wr(8'h3d, '{~ev[7:0]});
    chk(evalCfg, ev);
    $display("unlock done");
    sel = 1'b0;
    host.wr(8'h20, '{8'h08});
    chk(24'(unl), 24'h1);
    chk(24'(pd), 24'h0);
    rst = 1'b1;
    host.tick(3);
    rst = 1'b0;
    host.tick(4);
    chk(24'(ka), 24'h1);
    chk(24'(unl), 24'h0);
    $display("second reset done");
    host.wr(8'h20, '{8'h00});
    chk(24'(ka), 24'h0);
    chk(24'(pd), 24'h0);
    host.devAddr = 7'h41;
    host.wr(8'h20, '{8'h08});
    chk(24'(ackOk), 24'h0);
    chk(24'(unl), 24'h0);
    chk(24'(ka), 24'h1);
    host.devAddr = 7'h40;
    rd(8'h30, '{8'h00});
    $display("addressing done");
    conclude();
  end
endmodule // test_anc_system_power_registers
`default_nettype wire
